// ---- hw/isp_ctl.v ----
`include "isp_ctl_map.vh"

module isp_ctl (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // special function register port
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  // core status and control
  input wire cpu_idle_i,
  input wire wake_i,
  output reg core_reset_o,
  output reg core_hold_o,
  output reg pc_clear_o,
  output reg exec_from_loader_o,
  output reg aux_ram_enable_o,
  output reg isp_mode_o,
  // flash array
  output reg flash_start_o,
  output reg flash_bank_o,
  output reg [3:0] flash_ctrl_o,
  output reg flash_output_enable_o,
  output reg flash_chip_enable_o,
  output reg [15:0] flash_addr_o,
  output reg [7:0] flash_wdata_o,
  input wire [7:0] flash_rdata_i,
  input wire flash_done_i,
  // boot straps
  input wire p27_i,
  input wire p26_i,
  input wire p43_i
);

  localparam ST_WAIT = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam UL_CLOSED = 2'h0;
  localparam UL_HALF = 2'h1;
  localparam UL_OPEN = 2'h2;

  // valid operation codes with their enables
  function op_valid;
    input [7:0] cmd;
    begin
      case (cmd[3:0])
        `CODE_ERASE: op_valid = cmd[`CMD_OE_BIT] & ~cmd[`CMD_CE_BIT];
        `CODE_PROGRAM: op_valid = cmd[`CMD_OE_BIT] & ~cmd[`CMD_CE_BIT];
        `CODE_READ: op_valid = ~cmd[`CMD_OE_BIT] & ~cmd[`CMD_CE_BIT];
        default: op_valid = 1'b0;
      endcase
    end
  endfunction

  // strobe aimed at one register offset
  function reg_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = strobe && addr == ofs;
    end
  endfunction

  reg [7:0] control_r;
  reg [7:0] command_r;
  reg [7:0] addr_hi_r;
  reg [7:0] addr_lo_r;
  reg [7:0] data_r;
  reg [1:0] unlock_r;
  reg state_r;
  reg pending_r;
  reg boot_from_loader_r;
  reg soft_rst_r;
  reg [2:0] settle_r;
  wire [2:0] strap_lvl;
  wire rst_all;
  wire wr_ctl;
  wire wr_cmd;
  wire reboot_req;
  wire prog_en;
  wire bank_ok;
  wire can_start;
  wire strap_hit;
  wire wr_unlock;
  wire wr_addr_hi;
  wire wr_addr_lo;
  wire wr_data;
  wire op_done;
  wire [3:0] cmd_code;
  wire [15:0] addr_word;

  strap_sync #(.WIDTH(3)) strap_sync_inst (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .pin_i({p43_i, p27_i, p26_i}),
    .level_o(strap_lvl)
  );

  // soft reboot folds into the same synchronous reset as the pin
  assign rst_all = !resetn_i | soft_rst_r;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  // one decode per register; each write strobe is combinational and stays high as long as sfr_wr_i does
  assign wr_ctl = reg_hit(sfr_wr_i, sfr_addr_i, `ISP_CONTROL_OFS)
    && unlock_r == UL_OPEN;
  assign wr_cmd = reg_hit(sfr_wr_i, sfr_addr_i, `FLASH_COMMAND_OFS);
  assign wr_unlock = reg_hit(sfr_wr_i, sfr_addr_i, `CONTROL_UNLOCK_OFS);
  assign wr_addr_hi = reg_hit(sfr_wr_i, sfr_addr_i, `FLASH_ADDRESS_HIGH_OFS);
  assign wr_addr_lo = reg_hit(sfr_wr_i, sfr_addr_i, `FLASH_ADDRESS_LOW_OFS);
  assign wr_data = reg_hit(sfr_wr_i, sfr_addr_i, `FLASH_DATA_OFS);
  assign op_done = state_r == ST_RUN && flash_done_i;
  assign cmd_code = command_r[3:0];
  assign addr_word = {addr_hi_r, addr_lo_r};
  assign reboot_req = wr_ctl && sfr_wdata_i[`CTL_REBOOT_BIT] && sfr_wdata_i[`CTL_LOC_SEL_BIT]
    && sfr_wdata_i[`CTL_PROG_EN_BIT];
  assign prog_en = control_r[`CTL_PROG_EN_BIT];
  // never rewrite the bank the loader is running from
  assign bank_ok = command_r[`CMD_BANK_BIT] != control_r[`CTL_LOC_SEL_BIT];
  assign can_start = isp_mode_o && prog_en && cpu_idle_i && pending_r && bank_ok
    && op_valid(command_r);
  assign strap_hit = (!strap_lvl[2]) || (!strap_lvl[1] && !strap_lvl[0]);

  // ----------------------------------------
  // soft reboot pulse
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      soft_rst_r <= 1'b0;
      core_reset_o <= 1'b0;
    end else begin
      soft_rst_r <= reboot_req && !soft_rst_r;
      core_reset_o <= reboot_req && !soft_rst_r;
    end
  end

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  // the cpu is held until the pins have passed the synchroniser,
  // so a pressed strap cannot be missed by the first fetch
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      settle_r <= 3'h0;
      core_hold_o <= 1'b1;
      boot_from_loader_r <= 1'b0;
    end else if (core_hold_o) begin
      if (settle_r == `STRAP_SETTLE_CYCLES) begin
        core_hold_o <= 1'b0;
        boot_from_loader_r <= strap_hit;
      end else begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      control_r <= `ISP_CONTROL_RST;
      command_r <= `FLASH_COMMAND_RST;
      addr_hi_r <= `FLASH_BYTE_RST;
      addr_lo_r <= `FLASH_BYTE_RST;
      unlock_r <= UL_CLOSED;
    end else begin
      if (wr_unlock) begin
        if (sfr_wdata_i == `UNLOCK_KEY_FIRST) begin
          unlock_r <= UL_HALF;
        end else if (sfr_wdata_i == `UNLOCK_KEY_SECOND && unlock_r == UL_HALF) begin
          unlock_r <= UL_OPEN;
        end else begin
          unlock_r <= UL_CLOSED;
        end
      end
      // bits 7, 6, 5, 3, 2 are not stored
      if (wr_ctl) begin
        control_r <= sfr_wdata_i & `CTL_WRITE_MASK;
      end
      if (wr_cmd) begin
        command_r <= {1'b0, sfr_wdata_i[6:0]};
      end
      if (wr_addr_hi) begin
        addr_hi_r <= sfr_wdata_i;
      end
      if (wr_addr_lo) begin
        addr_lo_r <= sfr_wdata_i;
      end
    end
  end

  // ----------------------------------------
  // programming mode and bank switch
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      isp_mode_o <= 1'b0;
      exec_from_loader_o <= 1'b0;
      pc_clear_o <= 1'b0;
      aux_ram_enable_o <= 1'b0;
    end else begin
      pc_clear_o <= 1'b0;
      aux_ram_enable_o <= control_r[`CTL_AUX_RAM_BIT];
      if (core_hold_o) begin
        exec_from_loader_o <= 1'b0;
        if (settle_r == `STRAP_SETTLE_CYCLES && strap_hit) begin
          exec_from_loader_o <= 1'b1;
        end
      end else if (!prog_en) begin
        // a running core may still fetch from flash, so leaving waits for idle as well
        if (cpu_idle_i) begin
          isp_mode_o <= 1'b0;
        end
      end else if (cpu_idle_i && wake_i) begin
        isp_mode_o <= 1'b1;
        if (!exec_from_loader_o) begin
          exec_from_loader_o <= 1'b1;
          pc_clear_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // flash operation sequencer
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      state_r <= ST_WAIT;
      pending_r <= 1'b0;
      data_r <= `FLASH_BYTE_RST;
      flash_start_o <= 1'b0;
      flash_bank_o <= 1'b0;
      flash_ctrl_o <= `CODE_READ;
      flash_output_enable_o <= 1'b0;
      flash_chip_enable_o <= 1'b1;
      flash_addr_o <= 16'h0000;
      flash_wdata_o <= `FLASH_BYTE_RST;
    end else begin
      flash_start_o <= 1'b0;
      if (wr_data) begin
        data_r <= sfr_wdata_i;
      end
      case (state_r)
        ST_WAIT: begin
          if (can_start) begin
            state_r <= ST_RUN;
            flash_start_o <= 1'b1;
            flash_bank_o <= command_r[`CMD_BANK_BIT];
            flash_ctrl_o <= cmd_code;
            flash_output_enable_o <= command_r[`CMD_OE_BIT];
            flash_chip_enable_o <= command_r[`CMD_CE_BIT];
            flash_wdata_o <= data_r;
            if (cmd_code == `CODE_ERASE) begin
              flash_addr_o <= 16'h0000;
            end else begin
              flash_addr_o <= addr_word;
            end
          end
        end
        ST_RUN: begin
          // an operation in flight is never cut short by the core waking
          if (flash_done_i) begin
            state_r <= ST_WAIT;
            flash_chip_enable_o <= 1'b1;
            if (flash_ctrl_o == `CODE_READ) begin
              data_r <= flash_rdata_i;
            end
          end
        end
        default: begin
          state_r <= ST_WAIT;
        end
      endcase
      // a new command wins over the completion clearing the old one
      if (wr_cmd) begin
        pending_r <= 1'b1;
      end else if (op_done) begin
        pending_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register reads, one cycle after the strobe
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_all) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        `ISP_CONTROL_OFS: sfr_rdata_o <= {boot_from_loader_r, control_r[6:0]};
        `FLASH_COMMAND_OFS: sfr_rdata_o <= command_r;
        `FLASH_ADDRESS_HIGH_OFS: sfr_rdata_o <= addr_hi_r;
        `FLASH_ADDRESS_LOW_OFS: sfr_rdata_o <= addr_lo_r;
        `FLASH_DATA_OFS: sfr_rdata_o <= data_r;
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule // isp_ctl

// ---- hw/isp_ctl_map.vh ----
`ifndef ISP_CTL_MAP_VH
`define ISP_CTL_MAP_VH
// Behaviour
// - flash operations start, and programming is entered and left, only while the core idles; a software reset leaves programming at any time
// - with programming enabled, idle then interrupt wake-up enters programming mode
// - programming enable at zero keeps flash read-only, no operation starts
// - wake-up with programming enabled from application bank runs the handler from loader
// - switching from application to loader bank clears the program counter
// - control bits 0, 1 and 7 all set cause a software reset of the cpu
// - software reset behaves like power-on reset and samples the straps again, rebooting into loader if a strap asks for it
// - control bit 7 reads one while running in boot-from-loader mode
// - control bit 4 enables the auxiliary ram
// - control bit 1 tells where the loader runs and which bank is the target
// - command bit 6 picks the target bank: application at 0, loader at 1
// - codes 0010 erase, 0001 program, 0000 read with matching output and chip enable
// - address bytes feed program and read; erase ignores the address
// - data register supplies program data and receives read data
// - after power-on boot from application bank unless the strap asks for loader
// - strap: port 2 bits 7 and 6 both low, or port 4 bit 3 low
// - control register writable only after unlock bytes 87 then 59

// ----------------------------------------
// special function register offsets
// ----------------------------------------
`define ISP_CONTROL_OFS 8'hBF
`define FLASH_COMMAND_OFS 8'hC7
`define FLASH_ADDRESS_HIGH_OFS 8'hC4
`define FLASH_ADDRESS_LOW_OFS 8'hC5
`define FLASH_DATA_OFS 8'hC6
`define CONTROL_UNLOCK_OFS 8'hF6

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTL_PROG_EN_BIT 0
`define CTL_LOC_SEL_BIT 1
`define CTL_AUX_RAM_BIT 4
`define CTL_REBOOT_BIT 7
`define CMD_BANK_BIT 6
`define CMD_OE_BIT 5
`define CMD_CE_BIT 4
`define CTL_WRITE_MASK 8'h13

// ----------------------------------------
// reset values, keys and codes
// ----------------------------------------
`define ISP_CONTROL_RST 8'h00
`define FLASH_COMMAND_RST 8'h00
`define FLASH_BYTE_RST 8'h00
`define UNLOCK_KEY_FIRST 8'h87
`define UNLOCK_KEY_SECOND 8'h59
`define CODE_ERASE 4'h2
`define CODE_PROGRAM 4'h1
`define CODE_READ 4'h0
`define STRAP_SETTLE_CYCLES 3'h4
`endif

// ---- hw/strap_sync.v ----
module strap_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // raw pins
  input wire [WIDTH-1:0] pin_i,
  // filtered levels
  output reg [WIDTH-1:0] level_o
);

  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  integer k;

  // ----------------------------------------
  // three stages, a change counts once stage two and three agree
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    s1_r <= pin_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (!resetn_i) begin
      level_o <= {WIDTH{1'b1}};
    end else begin
      for (k = 0; k < WIDTH; k = k + 1) begin
        if (s2_r[k] == s3_r[k]) begin
          level_o[k] <= s3_r[k];
        end
      end
    end
  end

endmodule // strap_sync

// ---- sim/isp_ctl_properties.sv ----
module isp_ctl_properties (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // register port
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  // core
  input wire cpu_idle_i,
  input wire wake_i,
  input wire core_reset_o,
  input wire core_hold_o,
  input wire pc_clear_o,
  input wire exec_from_loader_o,
  input wire isp_mode_o,
  // flash
  input wire flash_start_o,
  input wire flash_bank_o,
  input wire [3:0] flash_ctrl_o,
  input wire flash_output_enable_o,
  input wire flash_chip_enable_o,
  input wire [15:0] flash_addr_o,
  input wire flash_done_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_start_when_idle: assert property (
    flash_start_o |-> $past(cpu_idle_i) && $past(isp_mode_o)) else $error("start outside idle");
  a_start_code_legal: assert property (flash_start_o |-> !flash_chip_enable_o &&
    ((flash_ctrl_o == 4'h2 || flash_ctrl_o == 4'h1) ? flash_output_enable_o :
    (flash_ctrl_o == 4'h0 && !flash_output_enable_o))) else $error("bad start code");
  a_erase_zero_addr: assert property (
    flash_start_o && flash_ctrl_o == 4'h2 |-> flash_addr_o == 16'h0000) else $error("erase addr");
  a_op_held_stable: assert property (!flash_chip_enable_o && !flash_done_i |=>
    $stable(flash_bank_o) && $stable(flash_addr_o)) else $error("op outputs moved");
  a_ce_release_done: assert property (
    !flash_chip_enable_o && flash_done_i |=> flash_chip_enable_o) else $error("ce not released");
  a_entry_on_wake: assert property (
    $rose(isp_mode_o) |-> $past(wake_i) && $past(cpu_idle_i)) else $error("entry without wake");
  a_exit_when_idle: assert property (
    $fell(isp_mode_o) |-> $past(cpu_idle_i) || core_hold_o) else $error("exit outside idle");
  a_pc_clear_entry: assert property (pc_clear_o |->
    isp_mode_o && exec_from_loader_o && !$past(exec_from_loader_o)) else $error("pc clear");
  a_reboot_cause: assert property (core_reset_o |-> $past(sfr_wr_i) &&
    $past(sfr_addr_i) == 8'hBF && ($past(sfr_wdata_i) & 8'h83) == 8'h83) else $error("reboot");
  a_reboot_resets: assert property (
    core_reset_o |-> ##[1:4] (core_hold_o && !isp_mode_o)) else $error("reboot no reset");
  a_hold_after_reset: assert property (
    $rose(resetn_i) |-> core_hold_o [*5] ##1 !core_hold_o) else $error("hold length");
  cover property (flash_start_o && flash_ctrl_o == 4'h2);
  cover property (flash_start_o && flash_ctrl_o == 4'h0);
  cover property (core_reset_o);
endmodule // isp_ctl_properties

bind isp_ctl isp_ctl_properties isp_ctl_properties_inst (.core_clk_i, .resetn_i, .sfr_addr_i,
  .sfr_wdata_i, .sfr_wr_i, .cpu_idle_i, .wake_i, .core_reset_o, .core_hold_o, .pc_clear_o,
  .exec_from_loader_o, .isp_mode_o, .flash_start_o, .flash_bank_o, .flash_ctrl_o,
  .flash_output_enable_o, .flash_chip_enable_o, .flash_addr_o, .flash_done_i);

// ---- sim/flash_model.sv ----
module flash_model (
  // clock
  input wire logic core_clk_i,
  // operation
  input wire logic start_i,
  input wire logic bank_i,
  input wire logic [3:0] ctrl_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic slow_i,
  // answer
  output logic done_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:1][0:255];
  logic [7:0] cnt = 8'h00;
  logic busy = 1'b0;
  initial begin
    done_o = 1'b0;
    rdata_o = 8'h00;
    foreach (mem[b, a]) mem[b][a] = 8'hFF;
  end
  always @(posedge core_clk_i) begin
    done_o <= 1'b0;
    if (start_i) begin
      busy <= 1'b1;
      cnt <= slow_i ? 8'h28 : 8'h02;
    end else if (busy && cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      case (ctrl_i)
        // erase ignores the address
        4'h2: for (int a = 0; a < 256; a++) mem[bank_i][a] <= 8'hFF;
        // real cells only clear bits
        4'h1: mem[bank_i][addr_i[7:0]] <= mem[bank_i][addr_i[7:0]] & wdata_i;
        default: rdata_o <= mem[bank_i][addr_i[7:0]];
      endcase
    end else begin
      // released bus: a stale value must never look valid
      rdata_o <= ~rdata_o;
    end
  end
endmodule // flash_model

// ---- sim/in_system_flash_programming_test.sv ----
module in_system_flash_programming_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic cpu_idle_i = 1'b0;
  logic wake_i = 1'b0;
  logic p27_i = 1'b1;
  logic p26_i = 1'b1;
  logic p43_i = 1'b1;
  logic slow = 1'b0;
  logic [7:0] sfr_rdata_o, flash_wdata_o, flash_rdata_i;
  logic [3:0] flash_ctrl_o;
  logic [15:0] flash_addr_o;
  logic core_reset_o, core_hold_o, pc_clear_o, exec_from_loader_o, aux_ram_enable_o;
  logic isp_mode_o, flash_start_o, flash_bank_o, flash_output_enable_o;
  logic flash_chip_enable_o, flash_done_i;
  logic [20:0] seen_op = 21'h000000;
  int n_mismatch = 0;
  int check_count = 0;
  int n_start = 0;
  logic [7:0] refused_cmd [4] = '{8'h21, 8'h43, 8'h41, 8'h71};
  isp_ctl isp_ctl_inst (.core_clk_i, .resetn_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_rdata_o, .cpu_idle_i, .wake_i, .core_reset_o, .core_hold_o, .pc_clear_o,
    .exec_from_loader_o, .aux_ram_enable_o, .isp_mode_o, .flash_start_o, .flash_bank_o,
    .flash_ctrl_o, .flash_output_enable_o, .flash_chip_enable_o, .flash_addr_o,
    .flash_wdata_o, .flash_rdata_i, .flash_done_i, .p27_i, .p26_i, .p43_i);
  flash_model flash_model_inst (.core_clk_i, .start_i(flash_start_o), .bank_i(flash_bank_o),
    .ctrl_i(flash_ctrl_o), .addr_i(flash_addr_o), .wdata_i(flash_wdata_o), .slow_i(slow),
    .done_o(flash_done_i), .rdata_o(flash_rdata_i));
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (flash_start_o === 1'b1) begin
      n_start <= n_start + 1;
      seen_op <= {flash_bank_o, flash_ctrl_o, flash_addr_o};
    end
  end
  // --------------------------------
  // access tasks
  // --------------------------------
  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= addr;
    sfr_wdata_i <= data;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b1;
    sfr_addr_i <= addr;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    @(negedge core_clk_i);
    check(what, exp, sfr_rdata_o);
  endtask
  task automatic wait_done;
    for (int k = 0; k < 100 && flash_done_i !== 1'b1; k++) @(negedge core_clk_i);
    repeat (2) @(posedge core_clk_i);
  endtask
  task automatic flash_op(input logic [7:0] cmd, input logic slow_in);
    slow <= slow_in;
    wr(8'hC7, cmd);
    wait_done();
  endtask
  task automatic boot(input logic [2:0] straps);
    @(posedge core_clk_i);
    {p27_i, p26_i, p43_i} <= straps;
    resetn_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    boot(3'b111);
    check("loader_exec", 0, exec_from_loader_o);
    rd_check(8'hBF, 8'h00, "control");
    wr(8'hBF, 8'h01);
    rd_check(8'hBF, 8'h00, "locked control");
    wr(8'hF6, 8'h87);
    wr(8'hF6, 8'h59);
    wr(8'hBF, 8'h1D);
    rd_check(8'hBF, 8'h11, "control");
    check("aux_ram", 1, aux_ram_enable_o);
    rd_check(8'h80, 8'h00, "unmapped");
    wr(8'hC4, 8'h12);
    wr(8'hC5, 8'h34);
    wr(8'hC6, 8'hA5);
    flash_op(8'h61, 1'b0);
    check("starts", 0, n_start);
    @(posedge core_clk_i);
    cpu_idle_i <= 1'b1;
    @(posedge core_clk_i);
    wake_i <= 1'b1;
    @(posedge core_clk_i);
    wake_i <= 1'b0;
    @(negedge core_clk_i);
    check("pc_clear", 1, pc_clear_o);
    check("loader_exec", 1, exec_from_loader_o);
    check("isp_mode", 1, isp_mode_o);
    wait_done();
    check("program op", {1'b1, 4'h1, 16'h1234}, seen_op);
    wr(8'hC6, 8'h00);
    flash_op(8'h40, 1'b1);
    rd_check(8'hC6, 8'hA5, "read byte");
    flash_op(8'h62, 1'b0);
    check("erase op", {1'b1, 4'h2, 16'h0000}, seen_op);
    flash_op(8'h40, 1'b0);
    rd_check(8'hC6, 8'hFF, "erased byte");
    for (int i = 0; i < 4; i++) flash_op(refused_cmd[i], 1'b0);
    check("starts", 4, n_start);
    wr(8'hBF, 8'h10);
    flash_op(8'h61, 1'b0);
    check("starts", 4, n_start);
    check("isp_mode", 0, isp_mode_o);
    cpu_idle_i <= 1'b0;
    wr(8'hBF, 8'h83);
    repeat (12) @(posedge core_clk_i);
    rd_check(8'hBF, 8'h00, "rebooted control");
    check("aux_ram", 0, aux_ram_enable_o);
    wr(8'hBF, 8'h01);
    rd_check(8'hBF, 8'h00, "relocked control");
    boot(3'b001);
    rd_check(8'hBF, 8'h80, "strap control");
    check("loader_exec", 1, exec_from_loader_o);
    boot(3'b110);
    rd_check(8'hBF, 8'h80, "strap control");
    wrap_up();
  end
  initial begin
    #(4000 * 50);
    n_mismatch++;
    wrap_up();
  end
endmodule // in_system_flash_programming_test
